// *** pkg/dacl_pkg.sv ***
// constants, field layouts and types of the converter load and trigger block
`default_nettype none
package dacl_pkg;
	localparam int MAX_CHANNELS = 2;
	localparam int SAMPLE_WIDTH = 12;
	localparam int BYTE_WIDTH = 8;

	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int WAKEUP_TIME_NS = 10_000;
	localparam int WAKEUP_CYCLES = (WAKEUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRIGGER_LOAD_CYCLES = 3;
	localparam int LOAD_PIPE_WIDTH = TRIGGER_LOAD_CYCLES - 1;
	localparam int WAKE_COUNT_WIDTH = 16;

	// byte addresses, per channel block of CHANNEL_STRIDE
	localparam int ADDR_WIDTH = 8;
	localparam logic [7:0] CHANNEL_STRIDE = 8'h20;
	localparam logic [4:0] OFF_CHANNEL_CONTROL_ONE = 5'h00;
	localparam logic [4:0] OFF_BYTE_HOLDING = 5'h04;
	localparam logic [4:0] OFF_LEFT_HOLDING_HIGH = 5'h08;
	localparam logic [4:0] OFF_LEFT_HOLDING_LOW = 5'h0C;
	localparam logic [4:0] OFF_RIGHT_HOLDING_HIGH = 5'h10;
	localparam logic [4:0] OFF_RIGHT_HOLDING_LOW = 5'h14;
	localparam logic [4:0] OFF_CONVERTER_OUTPUT = 5'h18;
	localparam logic [7:0] OFF_SOFT_TRIGGER = 8'h40;
	localparam logic [7:0] OFF_GROUP_CONTROL = 8'h44;
	localparam int READY_BIT = 16;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [7:0] CONTROL_RESET = 8'h00;

	typedef enum logic [2:0] {
		SRC_FIRST_TIMER  = 3'b000,
		SRC_SECOND_TIMER = 3'b001,
		SRC_EXTERNAL_PIN = 3'b010,
		SRC_SOFTWARE     = 3'b111
	} dacl_source_type;

	// index of each synchronised source in the edge vector
	localparam int EDGE_FIRST_TIMER = 0;
	localparam int EDGE_SECOND_TIMER = 1;
	localparam int EDGE_EXTERNAL_PIN = 2;
	localparam int EDGE_COUNT = 3;

	typedef enum logic [2:0] {
		HOLD_NONE       = 3'b000,
		HOLD_BYTE       = 3'b001,
		HOLD_LEFT_HIGH  = 3'b010,
		HOLD_LEFT_LOW   = 3'b011,
		HOLD_RIGHT_HIGH = 3'b100,
		HOLD_RIGHT_LOW  = 3'b101
	} dacl_hold_type;

	// channel_control_one layout, bit 0 first from the right
	typedef struct packed {
		logic [1:0] reserved;
		logic [2:0] triggerSourceSelect;
		logic       triggerGate;
		logic       outputBufferOff;
		logic       powerOn;
	} dacl_control_type;

	typedef struct packed {
		logic [2:0] first;
		logic [2:0] second;
		logic [2:0] third;
		logic [2:0] rise;
	} dacl_sync_state_type;

	typedef struct packed {
		logic [SAMPLE_WIDTH-1:0]     holding;
		logic [SAMPLE_WIDTH-1:0]     outputValue;
		logic [LOAD_PIPE_WIDTH-1:0]  delay;
		logic [WAKE_COUNT_WIDTH-1:0] wakeCount;
		logic                        ready;
		logic                        loadDone;
	} dacl_channel_state_type;

	typedef struct packed {
		logic                                   awready;
		logic                                   wready;
		logic                                   bvalid;
		logic [1:0]                             bresp;
		logic                                   awHeld;
		logic                                   wHeld;
		logic [ADDR_WIDTH-1:0]                  awAddr;
		logic [BYTE_WIDTH-1:0]                  wByte;
		logic                                   wLane;
		logic                                   arready;
		logic                                   rvalid;
		logic [1:0]                             rresp;
		logic [31:0]                            rdata;
		dacl_control_type [MAX_CHANNELS-1:0]    control;
		logic [MAX_CHANNELS-1:0]                softTrigger;
		logic                                   grouped;
	} dacl_top_state_type;
endpackage : dacl_pkg
`default_nettype wire

// *** verification/dacl_monitor.sv ***
// assertion checker on the ports of the converter load and trigger block
`default_nettype none
module dacl_monitor #(
	parameter int WAKEUP_CYCLES = 4
) (
	input wire logic		clk_sys,
	input wire logic		reset,
	input wire logic		awvalid,
	input wire logic		awready,
	input wire logic		wvalid,
	input wire logic		wready,
	input wire logic [1:0]		bresp,
	input wire logic		bvalid,
	input wire logic		bready,
	input wire logic		arvalid,
	input wire logic		arready,
	input wire logic [31:0]		rdata,
	input wire logic		rvalid,
	input wire logic		rready,
	input wire logic [1:0]		channelPowerOn,
	input wire logic [1:0]		channelReady,
	input wire logic [1:0]		loadStrobe,
	input wire logic [1:0][11:0]	converterOutputValue
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WAKE_MAX = WAKEUP_CYCLES + 4;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////
	chk_write_answer: assert property (awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
		else $error("write response late");
	chk_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	chk_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read response late");
	chk_load_ready: assert property ((loadStrobe & ~channelReady) == 2'h0)
		else $error("load while not ready");
	chk_ready_power: assert property (!channelPowerOn[0] |=> !channelReady[0])
		else $error("ready without power");
	chk_wake_delay: assert property ($rose(channelPowerOn[0]) |=> !channelReady[0] ##[1:WAKE_MAX] channelReady[0])
		else $error("startup delay wrong");
	chk_value_stable: assert property (!loadStrobe[0] |-> $stable(converterOutputValue[0]))
		else $error("output changed without load");
	cov_load_both: cover property (loadStrobe == 2'h3);
	cov_slave_error: cover property (bvalid && bresp == 2'h2);
	cov_read_wait: cover property (rvalid && !rready);
endmodule : dacl_monitor
bind dacl_top dacl_monitor #(.WAKEUP_CYCLES(WAKEUP_CYCLES)) dacl_monitor_inst (.*);
`default_nettype wire

// *** verification/dacl_trigger_model.sv ***
// timer and pin trigger sources driving pulses of random width
`default_nettype none
module dacl_trigger_model (
	input wire logic	clk_sys,
	input wire logic [2:0]	fire,
	output logic [2:0]	pins
);
	timeunit 1ns;
	timeprecision 1ps;
	int left[3];
	initial pins = 3'h0;
	////////////////////////////////////////////////////////////
	// each fire starts one pulse of one to three cycles, idle low
	always @(posedge clk_sys)
		for (int i = 0; i < 3; i++) begin
			if (fire[i]) left[i] = 1 + $urandom % 3;
			pins[i] <= left[i] > 0;
			if (left[i] > 0) left[i]--;
		end
endmodule : dacl_trigger_model
`default_nettype wire

// *** verification/tb_dacl_top.sv ***
// self-checking testbench of the converter load and trigger block
`default_nettype none
module tb_dacl_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic			clk_sys = 1'b0;
	logic			reset, awvalid, wvalid, bready, arvalid, rready;
	logic			awready, wready, bvalid, arready, rvalid;
	logic [7:0]		awaddr, araddr;
	logic [2:0]		awprot, arprot, fire;
	logic [31:0]		wdata, rdata;
	logic [3:0]		wstrb;
	logic [1:0]		bresp, rresp, channelPowerOn, outputBufferOff, channelReady, loadStrobe;
	logic [1:0][11:0]	converterOutputValue;
	wire			firstTimerPulse, secondTimerPulse, externalTriggerPin;
	logic [1:0]		bq[$];
	logic [33:0]		rq[$];
	logic [11:0]		lv[2][$];
	int			lt[2][$], lastLoad[2], cyc = 1, fail_count, checked;
	dacl_top #(.NUM_CHANNELS(2), .WAKEUP_CYCLES(4)) dacl_top_inst (.*);
	dacl_trigger_model dacl_trigger_model_inst (
		.clk_sys(clk_sys),
		.fire(fire),
		.pins({externalTriggerPin, secondTimerPulse, firstTimerPulse})
	);
	always #20 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task automatic expect_load(input int c, input logic [11:0] v, input int t);
		lv[c].push_back(v);
		lt[c].push_back(t);
	endtask : expect_load
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		logic aw, w, b;
		bq.push_back(r);
		awaddr <= a;
		wdata <= {24'($urandom), d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (int n = 0; n < 60; n++) begin
			@(negedge clk_sys);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid && bready;
			@(posedge clk_sys);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) begin
				bready <= 1'b0;
				return;
			end
			if (!bready) bready <= 1'($urandom % 2);
		end
		fail_count++;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		logic ar, r;
		rq.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		for (int n = 0; n < 60; n++) begin
			@(negedge clk_sys);
			ar = arvalid && arready;
			r = rvalid && rready;
			@(posedge clk_sys);
			if (ar) arvalid <= 1'b0;
			if (r) begin
				rready <= 1'b0;
				return;
			end
			if (!rready) rready <= 1'($urandom % 2);
		end
		fail_count++;
	endtask : rd
	// power down, program, probe a holding write, then power up and wait
	task automatic setup(input int c, input logic [7:0] v);
		wr(8'(c * 32), 8'h00, 2'h0);
		wr(8'(c * 32), v, 2'h0);
		wr(8'(c * 32 + 4), 8'($urandom), 2'h0);
		wr(8'(c * 32), v | 8'h01, 2'h0);
		for (int n = 0; n < 40 && !channelReady[c]; n++) @(posedge clk_sys);
		chk("ready", 34'h1, {33'h0, channelReady[c]});
	endtask : setup
	////////////////////////////////////////////////////////////
	always @(negedge clk_sys) begin
		if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
		if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
		for (int i = 0; i < 2; i++)
			if (loadStrobe[i]) begin
				lastLoad[i] = cyc;
				if (lv[i].size() == 0) chk("unexpected load", 34'h0, 34'h1);
				else begin
					chk("output value", {22'h0, lv[i].pop_front()}, {22'h0, converterOutputValue[i]});
					if (lt[i][0] != 0) chk("load cycle", 34'(lt[i][0]), 34'(cyc));
					void'(lt[i].pop_front());
				end
			end
		cyc++;
	end
	////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] b, h, l;
		void'($urandom(40555));
		reset = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h0000_0000_0000;
		{awprot, arprot, fire} = 9'h000;
		wstrb = 4'hF;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd(8'h00, 34'h0);
		rd(8'h44, 34'h0);
		rd(8'h1C, 34'h2_0000_0000);
		wr(8'h48, 8'h01, 2'h2);
		setup(0, 8'h3A);
		chk("buffer off", 34'h1, {33'h0, outputBufferOff[0]});
		b = 8'($urandom);
		h = 8'($urandom);
		l = 8'($urandom);
		expect_load(0, {b, 4'h0}, 0);
		wr(8'h04, b, 2'h0);
		wr(8'h08, h, 2'h0);
		expect_load(0, {h, l[7:4]}, 0);
		wr(8'h0C, l, 2'h0);
		wr(8'h10, h, 2'h0);
		expect_load(0, {h[3:0], l}, 0);
		wr(8'h14, l, 2'h0);
		rd(8'h18, {18'h0_0001, 4'h0, h[3:0], l});
		setup(0, 8'h3E);
		wr(8'h04, b, 2'h0);
		expect_load(0, {b, 4'h0}, 0);
		wr(8'h40, 8'h01, 2'h0);
		repeat (8) @(posedge clk_sys);
		rd(8'h40, 34'h0);
		for (int k = 0; k < 4; k++) begin
			setup(0, {2'h0, 3'(k), 3'h6});
			wr(8'h00, 8'h3F, 2'h0);
			rd(8'h00, {28'h0, 3'(k), 3'h7});
			b = 8'($urandom);
			wr(8'h04, b, 2'h0);
			fire <= 3'h7 & ~(3'h1 << k);
			@(posedge clk_sys);
			fire <= 3'h0;
			repeat (12) @(posedge clk_sys);
			if (k < 3) begin
				expect_load(0, {b, 4'h0}, cyc + 7);
				fire <= 3'h1 << k;
				@(posedge clk_sys);
				fire <= 3'h0;
				repeat (12) @(posedge clk_sys);
			end
		end
		setup(0, 8'h3A);
		setup(1, 8'h02);
		wr(8'h44, 8'h01, 2'h0);
		wr(8'h24, h, 2'h0);
		expect_load(0, {b, 4'h0}, 0);
		expect_load(1, {h, 4'h0}, 0);
		wr(8'h04, b, 2'h0);
		chk("group sync", 34'(lastLoad[0]), 34'(lastLoad[1]));
		repeat (10) @(posedge clk_sys);
		chk("loads left", 34'h0, 34'(lv[0].size() + lv[1].size()));
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		test_done();
	end
endmodule : tb_dacl_top
`default_nettype wire

// *** verilog/dacl_channel.sv ***
// one converter channel: holding data, startup delay and output-data load
`default_nettype none
module dacl_channel #(
	parameter int WAKEUP_CYCLES = dacl_pkg::WAKEUP_CYCLES
) (
	input  wire logic                                clk_sys,
	input  wire logic                                reset,
	input  wire logic                                powerOn,
	input  wire logic                                holdWrite,
	input  wire dacl_pkg::dacl_hold_type             holdKind,
	input  wire logic [dacl_pkg::BYTE_WIDTH-1:0]     holdByte,
	input  wire logic                                writeLoad,
	input  wire logic                                triggerEvent,
	output logic                                     busy,
	output logic                                     ready,
	output logic                                     loadDone,
	output logic      [dacl_pkg::SAMPLE_WIDTH-1:0]   holdingValue,
	output logic      [dacl_pkg::SAMPLE_WIDTH-1:0]   outputValue
);
	localparam logic [dacl_pkg::WAKE_COUNT_WIDTH-1:0] WAKE_LIMIT = dacl_pkg::WAKE_COUNT_WIDTH'(WAKEUP_CYCLES);
	localparam int PW = dacl_pkg::LOAD_PIPE_WIDTH;

	dacl_pkg::dacl_channel_state_type state;
	dacl_pkg::dacl_channel_state_type next_state;

	always_comb begin
		logic [dacl_pkg::SAMPLE_WIDTH-1:0] hold;
		hold = state.holding;
		next_state = state;
		next_state.loadDone = 1'b0;

		if (holdWrite) begin
			unique case (holdKind)
				dacl_pkg::HOLD_BYTE:       hold = {holdByte, 4'h0};
				dacl_pkg::HOLD_LEFT_HIGH:  hold[11:4] = holdByte;
				dacl_pkg::HOLD_LEFT_LOW:   hold[3:0] = holdByte[7:4];
				dacl_pkg::HOLD_RIGHT_HIGH: hold[11:8] = holdByte[3:0];
				dacl_pkg::HOLD_RIGHT_LOW:  hold[7:0] = holdByte;
				dacl_pkg::HOLD_NONE: begin
				end
				default: begin
				end
			endcase
		end
		next_state.holding = hold;

		// startup delay after power-on
		if (!powerOn) begin
			next_state.wakeCount = '0;
			next_state.ready = 1'b0;
		end else if (state.wakeCount < WAKE_LIMIT) begin
			next_state.wakeCount = state.wakeCount + 1'b1;
		end else begin
			next_state.ready = 1'b1;
		end

		// trigger seen in cycle t loads at edge t+3
		if (PW > 1) begin
			next_state.delay = {state.delay[PW-2:0], triggerEvent & state.ready};
		end else begin
			next_state.delay = PW'(triggerEvent & state.ready);
		end
		if (state.delay[PW-1] && state.ready) begin
			next_state.outputValue = state.holding;
			next_state.loadDone = 1'b1;
		end else if (writeLoad && state.ready) begin
			next_state.outputValue = hold;
			next_state.loadDone = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign busy = |state.delay;
	assign ready = state.ready;
	assign loadDone = state.loadDone;
	assign holdingValue = state.holding;
	assign outputValue = state.outputValue;
endmodule : dacl_channel
`default_nettype wire

// *** verilog/dacl_edge_sync.sv ***
// two-stage synchroniser with rising edge detection for the hardware trigger sources
`default_nettype none
module dacl_edge_sync (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [2:0] rawTrigger,
	output logic      [2:0] triggerRise
);
	dacl_pkg::dacl_sync_state_type state;
	dacl_pkg::dacl_sync_state_type next_state;

	always_comb begin
		next_state = state;
		next_state.first = rawTrigger;
		next_state.second = state.first;
		next_state.third = state.second;
		next_state.rise = state.second & ~state.third;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign triggerRise = state.rise;
endmodule : dacl_edge_sync
`default_nettype wire

// *** verilog/dacl_top.sv ***
// converter channel load and trigger control behind an AXI4-Lite register slave
`default_nettype none
module dacl_top #(
	parameter int NUM_CHANNELS = 2,
	parameter int WAKEUP_CYCLES = dacl_pkg::WAKEUP_CYCLES
) (
	input  wire logic                                                 clk_sys,
	input  wire logic                                                 reset,
	input  wire logic [dacl_pkg::ADDR_WIDTH-1:0]                      awaddr,
	input  wire logic [2:0]                                           awprot,
	input  wire logic                                                 awvalid,
	output logic                                                      awready,
	input  wire logic [31:0]                                          wdata,
	input  wire logic [3:0]                                           wstrb,
	input  wire logic                                                 wvalid,
	output logic                                                      wready,
	output logic      [1:0]                                           bresp,
	output logic                                                      bvalid,
	input  wire logic                                                 bready,
	input  wire logic [dacl_pkg::ADDR_WIDTH-1:0]                      araddr,
	input  wire logic [2:0]                                           arprot,
	input  wire logic                                                 arvalid,
	output logic                                                      arready,
	output logic      [31:0]                                          rdata,
	output logic      [1:0]                                           rresp,
	output logic                                                      rvalid,
	input  wire logic                                                 rready,
	input  wire logic                                                 firstTimerPulse,
	input  wire logic                                                 secondTimerPulse,
	input  wire logic                                                 externalTriggerPin,
	output logic      [dacl_pkg::MAX_CHANNELS-1:0]                    channelPowerOn,
	output logic      [dacl_pkg::MAX_CHANNELS-1:0]                    outputBufferOff,
	output logic      [dacl_pkg::MAX_CHANNELS-1:0]                    channelReady,
	output logic      [dacl_pkg::MAX_CHANNELS-1:0]                    loadStrobe,
	output logic      [dacl_pkg::MAX_CHANNELS-1:0][dacl_pkg::SAMPLE_WIDTH-1:0] converterOutputValue
);
	localparam int MC = dacl_pkg::MAX_CHANNELS;
	localparam logic TWO_CHANNELS = (NUM_CHANNELS > 1);

	dacl_pkg::dacl_top_state_type state;
	dacl_pkg::dacl_top_state_type next_state;

	logic [dacl_pkg::EDGE_COUNT-1:0]                    edgeRise;
	logic [MC-1:0]                                      chBusy;
	logic [MC-1:0]                                      chLoadDone;
	logic [MC-1:0][dacl_pkg::SAMPLE_WIDTH-1:0]          chHolding;
	logic [MC-1:0]                                      holdWrite;
	dacl_pkg::dacl_hold_type [MC-1:0]                   holdKind;
	logic [MC-1:0]                                      writeLoad;
	logic [MC-1:0]                                      triggerEvent;
	logic [MC-1:0]                                      ownWriteLoad;
	logic [MC-1:0]                                      ownTrigger;

	////////////////////////////////////////////////////////////////////////////
	// hardware trigger synchronisation

	dacl_edge_sync u_edge_sync (
		.clk_sys     (clk_sys),
		.reset       (reset),
		.rawTrigger  ({externalTriggerPin, secondTimerPulse, firstTimerPulse}),
		.triggerRise (edgeRise)
	);

	////////////////////////////////////////////////////////////////////////////
	// channels

	genvar ch;
	generate
		for (ch = 0; ch < MC; ch++) begin : g_channel
			dacl_channel #(
				.WAKEUP_CYCLES (WAKEUP_CYCLES)
			) u_channel (
				.clk_sys      (clk_sys),
				.reset        (reset),
				.powerOn      (state.control[ch].powerOn),
				.holdWrite    (holdWrite[ch]),
				.holdKind     (holdKind[ch]),
				.holdByte     (state.wByte),
				.writeLoad    (writeLoad[ch]),
				.triggerEvent (triggerEvent[ch]),
				.busy         (chBusy[ch]),
				.ready        (channelReady[ch]),
				.loadDone     (chLoadDone[ch]),
				.holdingValue (chHolding[ch]),
				.outputValue  (converterOutputValue[ch])
			);

			// selected trigger source of this channel
			always_comb begin
				dacl_pkg::dacl_control_type c;
				c = state.control[ch];
				ownTrigger[ch] = 1'b0;
				if (c.triggerGate) begin
					unique case (c.triggerSourceSelect)
						dacl_pkg::SRC_FIRST_TIMER:  ownTrigger[ch] = edgeRise[dacl_pkg::EDGE_FIRST_TIMER];
						dacl_pkg::SRC_SECOND_TIMER: ownTrigger[ch] = TWO_CHANNELS
							&& edgeRise[dacl_pkg::EDGE_SECOND_TIMER];
						dacl_pkg::SRC_EXTERNAL_PIN: ownTrigger[ch] = TWO_CHANNELS
							&& edgeRise[dacl_pkg::EDGE_EXTERNAL_PIN];
						dacl_pkg::SRC_SOFTWARE:     ownTrigger[ch] = state.softTrigger[ch] && !chBusy[ch]
							&& !chLoadDone[ch];
						default:                    ownTrigger[ch] = 1'b0;
					endcase
				end
				ownWriteLoad[ch] = holdWrite[ch] && !c.triggerGate
					&& (holdKind[ch] == dacl_pkg::HOLD_BYTE || holdKind[ch] == dacl_pkg::HOLD_LEFT_LOW
					|| holdKind[ch] == dacl_pkg::HOLD_RIGHT_LOW);
			end

			// grouped: the second channel follows the first
			if (ch == 0) begin : g_lead
				assign triggerEvent[ch] = ownTrigger[ch];
				assign writeLoad[ch] = ownWriteLoad[ch];
			end else begin : g_follow
				assign triggerEvent[ch] = state.grouped ? ownTrigger[0] : ownTrigger[ch];
				assign writeLoad[ch] = state.grouped ? ownWriteLoad[0] : ownWriteLoad[ch];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// register slave

	always_comb begin
		logic                               doWrite;
		logic                               wrChannel;
		logic                               rdChannel;
		logic                               wrMapped;
		logic                               rdMapped;
		logic [31:0]                        rdWord;
		logic [dacl_pkg::SAMPLE_WIDTH-1:0]  h;
		dacl_pkg::dacl_control_type         newControl;
		next_state = state;
		doWrite = state.awHeld && state.wHeld && !state.bvalid;
		wrChannel = state.awAddr[5];
		rdChannel = araddr[5];
		wrMapped = 1'b0;
		rdMapped = 1'b0;
		rdWord = '0;
		h = '0;
		newControl = state.control[0];
		holdWrite = '0;
		holdKind = {MC{dacl_pkg::HOLD_NONE}};

		if (awvalid && state.awready) begin
			next_state.awHeld = 1'b1;
			next_state.awAddr = awaddr;
		end
		if (wvalid && state.wready) begin
			next_state.wHeld = 1'b1;
			next_state.wByte = wdata[7:0];
			next_state.wLane = wstrb[0];
		end
		if (state.bvalid && bready) begin
			next_state.bvalid = 1'b0;
		end

		// soft trigger bits clear on load, a new set in the same cycle wins
		next_state.softTrigger = state.softTrigger & ~chLoadDone;

		if (doWrite) begin
			next_state.awHeld = 1'b0;
			next_state.wHeld = 1'b0;
			next_state.bvalid = 1'b1;
			if (state.awAddr[7:6] == 2'b00 && (!wrChannel || TWO_CHANNELS)) begin
				wrMapped = (state.awAddr[4:0] <= dacl_pkg::OFF_RIGHT_HOLDING_LOW)
					|| (state.awAddr[4:0] == dacl_pkg::OFF_CONVERTER_OUTPUT);
				if (state.wLane) begin
					unique case (state.awAddr[4:0])
						dacl_pkg::OFF_CHANNEL_CONTROL_ONE: begin
							newControl = state.wByte;
							newControl.reserved = 2'b00;
							if (state.control[wrChannel].powerOn) begin
								newControl.triggerSourceSelect = state.control[wrChannel].triggerSourceSelect;
							end
							next_state.control[wrChannel] = newControl;
						end
						dacl_pkg::OFF_BYTE_HOLDING:       holdKind[wrChannel] = dacl_pkg::HOLD_BYTE;
						dacl_pkg::OFF_LEFT_HOLDING_HIGH:  holdKind[wrChannel] = dacl_pkg::HOLD_LEFT_HIGH;
						dacl_pkg::OFF_LEFT_HOLDING_LOW:   holdKind[wrChannel] = dacl_pkg::HOLD_LEFT_LOW;
						dacl_pkg::OFF_RIGHT_HOLDING_HIGH: holdKind[wrChannel] = dacl_pkg::HOLD_RIGHT_HIGH;
						dacl_pkg::OFF_RIGHT_HOLDING_LOW:  holdKind[wrChannel] = dacl_pkg::HOLD_RIGHT_LOW;
						default: begin
						end
					endcase
					holdWrite[wrChannel] = (holdKind[wrChannel] != dacl_pkg::HOLD_NONE);
				end
			end else if (state.awAddr == dacl_pkg::OFF_SOFT_TRIGGER) begin
				wrMapped = 1'b1;
				if (state.wLane) begin
					next_state.softTrigger = next_state.softTrigger
						| (state.wByte[MC-1:0] & {TWO_CHANNELS, 1'b1});
				end
			end else if (state.awAddr == dacl_pkg::OFF_GROUP_CONTROL) begin
				wrMapped = 1'b1;
				if (state.wLane) begin
					next_state.grouped = state.wByte[0] && TWO_CHANNELS;
				end
			end
			next_state.bresp = wrMapped ? dacl_pkg::RESP_OKAY : dacl_pkg::RESP_SLVERR;
		end

		if (state.rvalid && rready) begin
			next_state.rvalid = 1'b0;
		end
		if (arvalid && state.arready) begin
			if (araddr[7:6] == 2'b00 && (!rdChannel || TWO_CHANNELS)) begin
				h = chHolding[rdChannel];
				rdMapped = 1'b1;
				unique case (araddr[4:0])
					dacl_pkg::OFF_CHANNEL_CONTROL_ONE: rdWord = {24'h00_0000, state.control[rdChannel]};
					dacl_pkg::OFF_BYTE_HOLDING:        rdWord = {24'h00_0000, h[11:4]};
					dacl_pkg::OFF_LEFT_HOLDING_HIGH:   rdWord = {24'h00_0000, h[11:4]};
					dacl_pkg::OFF_LEFT_HOLDING_LOW:    rdWord = {24'h00_0000, h[3:0], 4'h0};
					dacl_pkg::OFF_RIGHT_HOLDING_HIGH:  rdWord = {24'h00_0000, 4'h0, h[11:8]};
					dacl_pkg::OFF_RIGHT_HOLDING_LOW:   rdWord = {24'h00_0000, h[7:0]};
					dacl_pkg::OFF_CONVERTER_OUTPUT: begin
						rdWord[11:0] = converterOutputValue[rdChannel];
						rdWord[dacl_pkg::READY_BIT] = channelReady[rdChannel];
					end
					default: rdMapped = 1'b0;
				endcase
			end else if (araddr == dacl_pkg::OFF_SOFT_TRIGGER) begin
				rdMapped = 1'b1;
				rdWord[MC-1:0] = state.softTrigger;
			end else if (araddr == dacl_pkg::OFF_GROUP_CONTROL) begin
				rdMapped = 1'b1;
				rdWord[0] = state.grouped;
			end
			next_state.rvalid = 1'b1;
			next_state.rdata = rdMapped ? rdWord : 32'h0000_0000;
			next_state.rresp = rdMapped ? dacl_pkg::RESP_OKAY : dacl_pkg::RESP_SLVERR;
		end

		next_state.awready = !next_state.awHeld;
		next_state.wready = !next_state.wHeld;
		next_state.arready = !next_state.rvalid;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= '0;
			state.control <= {MC{dacl_pkg::CONTROL_RESET}};
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign awready = state.awready;
	assign wready = state.wready;
	assign bvalid = state.bvalid;
	assign bresp = state.bresp;
	assign arready = state.arready;
	assign rvalid = state.rvalid;
	assign rdata = state.rdata;
	assign rresp = state.rresp;
	assign loadStrobe = chLoadDone;

	generate
		for (ch = 0; ch < MC; ch++) begin : g_pins
			assign channelPowerOn[ch] = state.control[ch].powerOn;
			assign outputBufferOff[ch] = state.control[ch].outputBufferOff;
		end
	endgenerate
endmodule : dacl_top
`default_nettype wire
